// [common/ocp_defines.svh]
/*
 * Constants of the overcurrent fault block: register offsets, field positions,
 * reset values, threshold table and time base.
 * Assumes a 20 MHz ref_clk and byte-wide register access.
 */
`ifndef OCP_DEFINES_SVH
`define OCP_DEFINES_SVH

// Register offsets
`define OCP_ADDR_DOC_LOW 8'h16
`define OCP_ADDR_DOC_HIGH 8'h17
`define OCP_ADDR_COC_LOW 8'h18
`define OCP_ADDR_COC_HIGH 8'h19
`define OCP_ADDR_FAULT 8'h81
`define OCP_ADDR_STATUS 8'h82
`define OCP_ADDR_SWCTRL 8'h86
`define OCP_ADDR_HOSTCFG 8'h87

// Reset values
`define OCP_RST_LOW 8'hA0
`define OCP_RST_HIGH 8'h44
`define OCP_RST_SWCTRL 2'h3

// Field positions
`define OCP_HIGH_WMASK 8'h7F
`define OCP_THR_MSB 6
`define OCP_THR_LSB 4
`define OCP_UNIT_MSB 3
`define OCP_UNIT_LSB 2
`define OCP_CNT_MSB 1
`define OCP_BIT_DISCHARGE_OVERCURRENT_FAULT_FLAG 2
`define OCP_BIT_CHARGE_OVERCURRENT_FAULT_FLAG 1
`define OCP_BIT_LDPR 0
`define OCP_BIT_CHPR 1
`define OCP_BIT_CLRLF 7
`define OCP_BIT_PTRIG 6
`define OCP_BIT_HOST_SWITCH_CONTROL 1
`define OCP_BIT_DISCHARGE_SWITCH_ENABLE 0
`define OCP_BIT_HSC 6
`define OCP_BIT_OVR 4

// Discharge threshold table in mV; charge is a quarter of it
`define OCP_DOC_MV0 8'h04
`define OCP_DOC_MV1 8'h08
`define OCP_DOC_MV2 8'h10
`define OCP_DOC_MV3 8'h18
`define OCP_DOC_MV4 8'h20
`define OCP_DOC_MV5 8'h30
`define OCP_DOC_MV6 8'h40
`define OCP_DOC_MV7 8'h60
`define OCP_CHG_SHIFT 2

// Time base
`define OCP_CLK_HZ 20000000
`define OCP_US_PER_S 1000000
`define OCP_MS_PER_S 1000
`define OCP_S_PER_MIN 60
`define OCP_SETTLE_MS 3000
`define OCP_PERIOD_MS 256
`define OCP_CNT_MAX 10'h3FF

`endif

// [common/ocp_pkg.sv]
/*
 * Types of the overcurrent fault block.
 * Assumes ocp_defines.svh supplies all numeric constants.
 */
package ocp_pkg;
	// Load probe recovery sequence
	typedef enum logic [1:0] {RS_IDLE, RS_SETTLE, RS_PROBE, RS_GAP} ocp_rcv_e;
	typedef logic [31:0] ocp_cyc_t;
endpackage

// [logic/ocp_trip_timer.sv]
/*
 * Qualification timer: counts how long the sense level has stayed over the
 * threshold, in units of us, ms, s or min.
 * Assumes over is synchronous to ref_clk.
 */
`timescale 1ns/100ps
`include "ocp_defines.svh"
module ocp_trip_timer import ocp_pkg::*; #(
	parameter ocp_cyc_t US_CYC = 32'h0000_0014,
	parameter ocp_cyc_t MS_CYC = 32'h0000_4E20,
	parameter ocp_cyc_t SEC_CYC = 32'h0131_2D00,
	parameter ocp_cyc_t MIN_CYC = 32'h4786_8C00
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic over,
	input wire logic [1:0] unitSel,
	input wire logic [9:0] unitCount,
	output logic trip
);
	ocp_cyc_t pre_q, pre_d, unitLen;
	logic [9:0] elapsed_q, elapsed_d;

	////////////////////////////////////////////////////////////////////////////
	// Unit length and counting
	always_comb begin
		case (unitSel)
			2'h0: unitLen = US_CYC;
			2'h1: unitLen = MS_CYC;
			2'h2: unitLen = SEC_CYC;
			default: unitLen = MIN_CYC;
		endcase
		pre_d = pre_q;
		elapsed_d = elapsed_q;
		if (!over) begin
			pre_d = '0;
			elapsed_d = '0;
		end else if (pre_q >= unitLen - 32'h0000_0001) begin
			pre_d = '0;
			// Saturate so a long event cannot wrap back under the count
			if (elapsed_q != `OCP_CNT_MAX)
				elapsed_d = elapsed_q + 10'h001;
		end else begin
			pre_d = pre_q + 32'h0000_0001;
		end
		trip = over && (elapsed_q >= unitCount);
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			pre_q <= '0;
			elapsed_q <= '0;
		end else begin
			pre_q <= pre_d;
			elapsed_q <= elapsed_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks
	a_timer_restart: assert property (@(posedge ref_clk) disable iff (rst)
		!over |=> (elapsed_q == 10'h000) && (pre_q == '0)) else $error("timer not restarted");
	a_trip_needs_time: assert property (@(posedge ref_clk) disable iff (rst)
		trip |-> over && elapsed_q >= unitCount) else $error("trip before delay");
endmodule

// [logic/ocp_fault_detect.sv]
/*
 * Discharge and charge overcurrent detection, fault flags, automatic switch
 * shutdown and the load probe recovery sequence, with host override.
 * Assumes a byte register port from the host interface, digitised sense
 * magnitudes in mV, and a load sense comparator, all synchronous to ref_clk.
 */
`timescale 1ns/100ps
`include "ocp_defines.svh"
module ocp_fault_detect import ocp_pkg::*; #(
	parameter ocp_cyc_t US_CYC = `OCP_CLK_HZ / `OCP_US_PER_S,
	parameter ocp_cyc_t MS_CYC = `OCP_CLK_HZ / `OCP_MS_PER_S,
	parameter ocp_cyc_t SEC_CYC = `OCP_CLK_HZ,
	parameter ocp_cyc_t MIN_CYC = `OCP_CLK_HZ * `OCP_S_PER_MIN,
	parameter ocp_cyc_t SETTLE_CYC = `OCP_CLK_HZ / `OCP_MS_PER_S * `OCP_SETTLE_MS,
	parameter ocp_cyc_t PERIOD_CYC = `OCP_CLK_HZ / `OCP_MS_PER_S * `OCP_PERIOD_MS
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrEn,
	input wire logic regRdEn,
	output logic [7:0] regRdData,
	input wire logic [7:0] dischargeSenseMv,
	input wire logic [7:0] chargeSenseMv,
	input wire logic loadSenseLow,
	input wire logic [3:0] loadProbeWidth,
	input wire logic shortTrip,
	input wire logic otherFaultActive,
	output logic loadProbeEnable,
	output logic chargeSwitchOn,
	output logic dischargeSwitchOn
);
	// Register and status state
	logic [7:0] docLow_q, docLow_d, docHigh_q, docHigh_d;
	logic [7:0] cocLow_q, cocLow_d, cocHigh_q, cocHigh_d;
	logic chargeSwitchEnable_q, chargeSwitchEnable_d;
	logic dischargeSwitchEnable_q, dischargeSwitchEnable_d;
	logic hostSwitchControl_q, hostSwitchControl_d;
	logic hostLoadProbeOverride_q, hostLoadProbeOverride_d;
	logic dischargeFault_q, dischargeFault_d, chargeFault_q, chargeFault_d;
	logic loadPresent_q, loadPresent_d, chargerPresent_q, chargerPresent_d;
	logic autoOff_q, autoOff_d;
	logic [7:0] regRdData_q, regRdData_d;
	// Sequence state
	ocp_rcv_e rcv_q, rcv_d;
	ocp_cyc_t cnt_q, cnt_d, probeLen;
	logic probe_q, probe_d, chgOn_q, chgOn_d, dchOn_q, dchOn_d;
	// Decoded events
	logic docOver, cocOver, docTrip, cocTrip;
	logic wrSw, clearLoadFault, probeTrigger, probeDone, recoverNow, cocW1c;

	// Threshold table lookup shared by both directions
	function automatic logic [7:0] thrMv(input logic [2:0] code, input logic chg);
		logic [7:0] mv;
		case (code)
			3'h0: mv = `OCP_DOC_MV0;
			3'h1: mv = `OCP_DOC_MV1;
			3'h2: mv = `OCP_DOC_MV2;
			3'h3: mv = `OCP_DOC_MV3;
			3'h4: mv = `OCP_DOC_MV4;
			3'h5: mv = `OCP_DOC_MV5;
			3'h6: mv = `OCP_DOC_MV6;
			default: mv = `OCP_DOC_MV7;
		endcase
		return chg ? (mv >> `OCP_CHG_SHIFT) : mv;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Comparators and qualification timers
	assign docOver = dischargeSenseMv > thrMv(docHigh_q[`OCP_THR_MSB:`OCP_THR_LSB], 1'b0);
	assign cocOver = chargeSenseMv > thrMv(cocHigh_q[`OCP_THR_MSB:`OCP_THR_LSB], 1'b1);

	ocp_trip_timer #(.US_CYC(US_CYC), .MS_CYC(MS_CYC), .SEC_CYC(SEC_CYC), .MIN_CYC(MIN_CYC)) dischargeTimer (
		.ref_clk(ref_clk),
		.rst(rst),
		.over(docOver),
		.unitSel(docHigh_q[`OCP_UNIT_MSB:`OCP_UNIT_LSB]),
		.unitCount({docHigh_q[`OCP_CNT_MSB:0], docLow_q}),
		.trip(docTrip)
	);

	ocp_trip_timer #(.US_CYC(US_CYC), .MS_CYC(MS_CYC), .SEC_CYC(SEC_CYC), .MIN_CYC(MIN_CYC)) chargeTimer (
		.ref_clk(ref_clk),
		.rst(rst),
		.over(cocOver),
		.unitSel(cocHigh_q[`OCP_UNIT_MSB:`OCP_UNIT_LSB]),
		.unitCount({cocHigh_q[`OCP_CNT_MSB:0], cocLow_q}),
		.trip(cocTrip)
	);

	////////////////////////////////////////////////////////////////////////////
	// Write strobes; action bits self-clear, they have no storage
	assign wrSw = regWrEn && (regAddr == `OCP_ADDR_SWCTRL);
	assign clearLoadFault = wrSw && regWrData[`OCP_BIT_CLRLF] && hostLoadProbeOverride_q;
	assign probeTrigger = wrSw && regWrData[`OCP_BIT_PTRIG] && hostLoadProbeOverride_q;
	assign cocW1c = regWrEn && (regAddr == `OCP_ADDR_FAULT) && regWrData[`OCP_BIT_CHARGE_OVERCURRENT_FAULT_FLAG];
	assign probeLen = (loadProbeWidth == 4'h0) ? 32'h0000_0001 : MS_CYC * {28'h000_0000, loadProbeWidth};
	assign probeDone = (rcv_q == RS_PROBE) && (cnt_q >= probeLen - 32'h0000_0001);
	// Auto recovery only when the pin saw no load and nothing else holds the switches off
	assign recoverNow = probeDone && !hostLoadProbeOverride_q && !loadSenseLow
		&& !otherFaultActive && !chargeFault_q;

	////////////////////////////////////////////////////////////////////////////
	// Recovery sequence: settle, then probe pulses on a fixed period
	always_comb begin
		rcv_d = rcv_q;
		cnt_d = cnt_q + 32'h0000_0001;
		probe_d = 1'b0;
		case (rcv_q)
			RS_IDLE: begin
				cnt_d = '0;
				if (probeTrigger) begin
					rcv_d = RS_PROBE;
				end else if ((docTrip || shortTrip) && !hostLoadProbeOverride_q) begin
					rcv_d = RS_SETTLE;
				end
			end
			RS_SETTLE: begin
				if (cnt_q >= SETTLE_CYC - 32'h0000_0001) begin
					rcv_d = RS_PROBE;
					cnt_d = '0;
				end
			end
			RS_PROBE: begin
				probe_d = !probeDone;
				if (probeDone) begin
					// Period counts from probe start, so the counter runs on
					if (hostLoadProbeOverride_q || recoverNow)
						rcv_d = RS_IDLE;
					else
						rcv_d = RS_GAP;
				end
			end
			RS_GAP: begin
				if (cnt_q >= PERIOD_CYC - 32'h0000_0001) begin
					rcv_d = RS_PROBE;
					cnt_d = '0;
				end
			end
			default: begin
				rcv_d = RS_IDLE;
				cnt_d = '0;
			end
		endcase
		// Host override parks the automatic sequence between host probes
		if (hostLoadProbeOverride_q && (rcv_q == RS_SETTLE || rcv_q == RS_GAP)) begin
			rcv_d = RS_IDLE;
			cnt_d = '0;
		end
		if (rcv_d == RS_PROBE && rcv_q != RS_PROBE)
			probe_d = 1'b1;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rcv_q <= RS_IDLE;
			cnt_q <= '0;
			probe_q <= 1'b0;
		end else begin
			rcv_q <= rcv_d;
			cnt_q <= cnt_d;
			probe_q <= probe_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Configuration registers and host control bits
	always_comb begin
		docLow_d = docLow_q;
		docHigh_d = docHigh_q;
		cocLow_d = cocLow_q;
		cocHigh_d = cocHigh_q;
		chargeSwitchEnable_d = chargeSwitchEnable_q;
		dischargeSwitchEnable_d = dischargeSwitchEnable_q;
		hostSwitchControl_d = hostSwitchControl_q;
		hostLoadProbeOverride_d = hostLoadProbeOverride_q;
		if (regWrEn) begin
			case (regAddr)
				`OCP_ADDR_DOC_LOW: docLow_d = regWrData;
				`OCP_ADDR_DOC_HIGH: docHigh_d = regWrData & `OCP_HIGH_WMASK; // Top bit has no storage
				`OCP_ADDR_COC_LOW: cocLow_d = regWrData;
				`OCP_ADDR_COC_HIGH: cocHigh_d = regWrData & `OCP_HIGH_WMASK;
				`OCP_ADDR_SWCTRL: begin
					chargeSwitchEnable_d = regWrData[`OCP_BIT_HOST_SWITCH_CONTROL];
					dischargeSwitchEnable_d = regWrData[`OCP_BIT_DISCHARGE_SWITCH_ENABLE];
				end
				`OCP_ADDR_HOSTCFG: begin
					hostSwitchControl_d = regWrData[`OCP_BIT_HSC];
					hostLoadProbeOverride_d = regWrData[`OCP_BIT_OVR];
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			docLow_q <= `OCP_RST_LOW;
			docHigh_q <= `OCP_RST_HIGH;
			cocLow_q <= `OCP_RST_LOW;
			cocHigh_q <= `OCP_RST_HIGH;
			chargeSwitchEnable_q <= 1'(`OCP_RST_SWCTRL >> `OCP_BIT_HOST_SWITCH_CONTROL);
			dischargeSwitchEnable_q <= 1'(`OCP_RST_SWCTRL >> `OCP_BIT_DISCHARGE_SWITCH_ENABLE);
			hostSwitchControl_q <= 1'b0;
			hostLoadProbeOverride_q <= 1'b0;
		end else begin
			docLow_q <= docLow_d;
			docHigh_q <= docHigh_d;
			cocLow_q <= cocLow_d;
			cocHigh_q <= cocHigh_d;
			chargeSwitchEnable_q <= chargeSwitchEnable_d;
			dischargeSwitchEnable_q <= dischargeSwitchEnable_d;
			hostSwitchControl_q <= hostSwitchControl_d;
			hostLoadProbeOverride_q <= hostLoadProbeOverride_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Fault and presence flags; a new trip always beats a clear
	always_comb begin
		dischargeFault_d = dischargeFault_q;
		loadPresent_d = loadPresent_q;
		chargeFault_d = chargeFault_q;
		chargerPresent_d = chargerPresent_q;
		autoOff_d = autoOff_q;
		if (probeDone)
			loadPresent_d = loadSenseLow;
		if (recoverNow) begin
			dischargeFault_d = 1'b0;
			autoOff_d = 1'b0;
		end
		if (clearLoadFault)
			dischargeFault_d = 1'b0;
		if (cocW1c) begin
			chargeFault_d = 1'b0;
			chargerPresent_d = 1'b0;
			if (!dischargeFault_q && !otherFaultActive)
				autoOff_d = 1'b0;
		end
		if (docTrip) begin
			dischargeFault_d = 1'b1;
			loadPresent_d = 1'b1;
		end
		if (cocTrip) begin
			chargeFault_d = 1'b1;
			chargerPresent_d = 1'b1;
		end
		// Host control 1 leaves switch shutdown to the host
		if ((docTrip || cocTrip) && !hostSwitchControl_q)
			autoOff_d = 1'b1;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dischargeFault_q <= 1'b0;
			loadPresent_q <= 1'b0;
			chargeFault_q <= 1'b0;
			chargerPresent_q <= 1'b0;
			autoOff_q <= 1'b0;
		end else begin
			dischargeFault_q <= dischargeFault_d;
			loadPresent_q <= loadPresent_d;
			chargeFault_q <= chargeFault_d;
			chargerPresent_q <= chargerPresent_d;
			autoOff_q <= autoOff_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Read data and switch drive, registered so outputs come from flops
	always_comb begin
		regRdData_d = regRdData_q;
		if (regRdEn) begin
			regRdData_d = 8'h00;
			case (regAddr)
				`OCP_ADDR_DOC_LOW: regRdData_d = docLow_q;
				`OCP_ADDR_DOC_HIGH: regRdData_d = docHigh_q;
				`OCP_ADDR_COC_LOW: regRdData_d = cocLow_q;
				`OCP_ADDR_COC_HIGH: regRdData_d = cocHigh_q;
				`OCP_ADDR_FAULT: begin
					regRdData_d[`OCP_BIT_DISCHARGE_OVERCURRENT_FAULT_FLAG] = dischargeFault_q;
					regRdData_d[`OCP_BIT_CHARGE_OVERCURRENT_FAULT_FLAG] = chargeFault_q;
				end
				`OCP_ADDR_STATUS: begin
					regRdData_d[`OCP_BIT_LDPR] = loadPresent_q;
					regRdData_d[`OCP_BIT_CHPR] = chargerPresent_q;
				end
				`OCP_ADDR_SWCTRL: begin
					regRdData_d[`OCP_BIT_HOST_SWITCH_CONTROL] = chargeSwitchEnable_q;
					regRdData_d[`OCP_BIT_DISCHARGE_SWITCH_ENABLE] = dischargeSwitchEnable_q;
				end
				`OCP_ADDR_HOSTCFG: begin
					regRdData_d[`OCP_BIT_HSC] = hostSwitchControl_q;
					regRdData_d[`OCP_BIT_OVR] = hostLoadProbeOverride_q;
				end
				default: ;
			endcase
		end
		chgOn_d = chargeSwitchEnable_q && !autoOff_q;
		dchOn_d = dischargeSwitchEnable_q && !autoOff_q;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			regRdData_q <= 8'h00;
			chgOn_q <= 1'b0;
			dchOn_q <= 1'b0;
		end else begin
			regRdData_q <= regRdData_d;
			chgOn_q <= chgOn_d;
			dchOn_q <= dchOn_d;
		end
	end

	assign regRdData = regRdData_q;
	assign loadProbeEnable = probe_q;
	assign chargeSwitchOn = chgOn_q;
	assign dischargeSwitchOn = dchOn_q;

	////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	a_doc_sets_flags: assert property (docTrip |=> dischargeFault_q && loadPresent_q)
		else $error("discharge trip did not set flags");
	a_coc_sets_flags: assert property (cocTrip |=> chargeFault_q && chargerPresent_q)
		else $error("charge trip did not set flags");
	a_auto_off: assert property ((docTrip || cocTrip) && !hostSwitchControl_q |=> ##1 !chargeSwitchOn && !dischargeSwitchOn)
		else $error("switches not turned off");
	a_host_keeps: assert property (cocTrip && hostSwitchControl_q && !autoOff_q |=> !autoOff_q)
		else $error("host mode switched off by device");
	a_settle_probe: assert property ($rose(rcv_q == RS_SETTLE) |-> !loadProbeEnable ##1 !loadProbeEnable)
		else $error("probe during settle");
	a_probe_drive: assert property (rcv_q == RS_PROBE && !probeDone |-> loadProbeEnable)
		else $error("probe pulse missing");
	a_probe_sample: assert property (probeDone && !docTrip |=> loadPresent_q == $past(loadSenseLow))
		else $error("load present not sampled");
	a_recover: assert property (recoverNow && !docTrip && !cocTrip && dischargeSwitchEnable_q
		|=> !dischargeFault_q ##1 dischargeSwitchOn)
		else $error("auto recovery failed");
	a_clear_fault: assert property (clearLoadFault && !docTrip |=> !dischargeFault_q)
		else $error("clear load fault ignored");
	a_reserved_zero: assert property (regRdEn && regAddr == `OCP_ADDR_DOC_HIGH |=> !regRdData[7])
		else $error("reserved bit read as one");

	c_doc_trip: cover property (docTrip && !hostSwitchControl_q);
	c_auto_recover: cover property (recoverNow);
	c_host_probe: cover property (probeTrigger ##1 rcv_q == RS_PROBE);
	c_coc_trip: cover property (cocTrip);
endmodule

// [tb/ocp_load_model.sv]
/*
 * Load sense model: an attached load pulls the sense pin low under probe current.
 * Assumes probeOn is the block's registered probe output on ref_clk.
 */
`timescale 1ns/100ps
module ocp_load_model (
	input wire logic ref_clk,
	input wire logic probeOn,
	input wire logic attached,
	output logic senseLow
);
	// Pin is meaningless without probe current, so it wanders every cycle
	initial senseLow = 1'b0;
	always @(posedge ref_clk) begin
		senseLow <= probeOn ? attached : ~senseLow;
	end
endmodule

// [tb/test_ocp_fault_detect.sv]
/*
 * Self-checking bench of ocp_fault_detect: registers, thresholds, timers,
 * load probe recovery, host control. Assumes shortened time parameters.
 */
`timescale 1ns/100ps
module test_ocp_fault_detect;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] regAddr = 8'h00;
	logic [7:0] regWrData = 8'h00;
	logic regWrEn = 1'b0;
	logic regRdEn = 1'b0;
	logic [7:0] regRdData;
	logic [7:0] dischargeSenseMv = 8'h00;
	logic [7:0] chargeSenseMv = 8'h00;
	logic loadSenseLow;
	logic attached = 1'b1;
	logic [3:0] probeWidth = 4'h1;
	logic shortPulse = 1'b0;
	logic otherFault = 1'b0;
	logic loadProbeEnable;
	logic chargeSwitchOn;
	logic dischargeSwitchOn;
	logic [7:0] d;
	logic [7:0] t;
	logic [7:0] dt [8] = '{8'h04, 8'h08, 8'h10, 8'h18, 8'h20, 8'h30, 8'h40, 8'h60};
	int numErrors = 0;
	int nCompared = 0;
	int cycles = 0;
	int n;
	int p;

	////////////////////////////////////////////////////////////////////////
	// Unit count 2 for us keeps us and min apart in the timing test
	ocp_fault_detect #(.US_CYC(32'h0000_0002), .MS_CYC(32'h0000_0005), .SEC_CYC(32'h0000_000A),
		.MIN_CYC(32'h0000_0014), .SETTLE_CYC(32'h0000_0064), .PERIOD_CYC(32'h0000_0028)) dut (
		.ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
		.regRdEn(regRdEn), .regRdData(regRdData), .dischargeSenseMv(dischargeSenseMv),
		.chargeSenseMv(chargeSenseMv), .loadSenseLow(loadSenseLow), .loadProbeWidth(probeWidth),
		.shortTrip(shortPulse), .otherFaultActive(otherFault), .loadProbeEnable(loadProbeEnable),
		.chargeSwitchOn(chargeSwitchOn), .dischargeSwitchOn(dischargeSwitchOn));
	ocp_load_model load (.ref_clk(ref_clk), .probeOn(loadProbeEnable), .attached(attached),
		.senseLow(loadSenseLow));

	always #25 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////////////
	// Inputs always move 1 ns after the rising edge
	task cyc();
		@(posedge ref_clk);
		#1;
	endtask
	task chk(input logic [7:0] got, input logic [7:0] exp);
		nCompared++;
		if (got !== exp) begin
			numErrors++;
			$display("mismatch at %0t: saw %h, wanted %h", $time, got, exp);
		end
	endtask
	// Idle edge after each strobe so it is never raised in the step it fell
	task wr(input logic [7:0] a, input logic [7:0] v);
		regAddr = a;
		regWrData = v;
		regWrEn = 1'b1;
		cyc();
		regWrEn = 1'b0;
		cyc();
	endtask
	task rd(input logic [7:0] a);
		regAddr = a;
		regRdEn = 1'b1;
		cyc();
		regRdEn = 1'b0;
		cyc();
		d = regRdData;
	endtask
	task cfg(input bit c, input logic [2:0] code, input logic [1:0] u, input logic [9:0] cnt);
		wr(c ? 8'h18 : 8'h16, cnt[7:0]);
		wr(c ? 8'h19 : 8'h17, {1'b0, code, u, cnt[9:8]});
	endtask
	task sense(input bit c, input logic [7:0] v);
		if (c) chargeSenseMv = v;
		else dischargeSenseMv = v;
	endtask
	task clr(input bit c);
		sense(c, 8'h00);
		cyc();
		wr(c ? 8'h81 : 8'h86, c ? 8'h02 : 8'h83);
		rd(8'h81);
		chk(d, 8'h00);
	endtask
	function logic pick(input bit w);
		return w ? dischargeSwitchOn : loadProbeEnable;
	endfunction
	task waitSig(input bit w, input logic v);
		n = 0;
		while (pick(w) !== v && n < 500) begin
			cyc();
			n++;
		end
	endtask
	function logic [7:0] sw();
		return {6'h00, chargeSwitchOn, dischargeSwitchOn};
	endfunction

	////////////////////////////////////////////////////////////////////////
	task testRegs();
		logic [7:0] a [9] = '{8'h16, 8'h17, 8'h18, 8'h19, 8'h86, 8'h87, 8'h81, 8'h82, 8'h20};
		logic [7:0] e [9] = '{8'hA0, 8'h44, 8'hA0, 8'h44, 8'h03, 8'h00, 8'h00, 8'h00, 8'h00};
		for (int i = 0; i < 9; i++) begin
			rd(a[i]);
			chk(d, e[i]);
		end
		wr(8'h17, 8'hFF);
		rd(8'h17);
		chk(d, 8'h7F);
		wr(8'h17, 8'h44);
		$display("register test done");
	endtask
	task testRecover();
		wr(8'h87, 8'h00);
		cfg(0, 3'h0, 2'h0, 10'h000);
		sense(0, 8'h10);
		cyc();
		sense(0, 8'h00);
		waitSig(0, 1'b1);
		chk({7'h00, n >= 99 && n <= 103}, 8'h01);
		chk(sw(), 8'h00);
		waitSig(0, 1'b0);
		p = n;
		waitSig(0, 1'b1);
		chk({7'h00, p + n >= 39 && p + n <= 41}, 8'h01);
		rd(8'h82);
		chk(d, 8'h01);
		attached = 1'b0;
		waitSig(1, 1'b1);
		chk({7'h00, n < 100}, 8'h01);
		rd(8'h81);
		chk(d, 8'h00);
		rd(8'h82);
		chk(d, 8'h00);
		$display("auto recovery test done");
	endtask
	task testHostCtl();
		wr(8'h87, 8'h40);
		sense(0, 8'h10);
		cyc();
		sense(0, 8'h00);
		repeat (4) cyc();
		chk(sw(), 8'h03);
		wr(8'h86, 8'h00);
		cyc();
		chk(sw(), 8'h00);
		n = 0;
		d = 8'h04;
		while (d !== 8'h00 && n < 200) begin
			rd(8'h81);
			n++;
		end
		chk(d, 8'h00);
		chk(sw(), 8'h00);
		wr(8'h86, 8'h03);
		cyc();
		chk(sw(), 8'h03);
		$display("host control test done");
	endtask
	task testOverride();
		wr(8'h87, 8'h10);
		attached = 1'b1;
		wr(8'h86, 8'h43);
		waitSig(0, 1'b1);
		chk({7'h00, n < 4}, 8'h01);
		repeat (10) cyc();
		rd(8'h82);
		chk(d, 8'h01);
		rd(8'h86);
		chk(d, 8'h03);
		attached = 1'b0;
		wr(8'h86, 8'h43);
		repeat (10) cyc();
		rd(8'h82);
		chk(d, 8'h00);
		$display("override test done");
	endtask
	// Charge side first, so load present is still clear there
	task testThresh();
		for (int c = 1; c >= 0; c--) begin
			for (int k = 0; k < 8; k++) begin
				t = c ? dt[k] >> 2 : dt[k];
				cfg(c[0], k[2:0], 2'h0, 10'h000);
				sense(c[0], t);
				repeat (4) cyc();
				rd(8'h81);
				chk(d, 8'h00);
				sense(c[0], t + 8'h01);
				repeat (4) cyc();
				rd(8'h81);
				chk(d, c ? 8'h02 : 8'h04);
				rd(8'h82);
				chk(d, c ? 8'h02 : 8'h01);
				if (c) chk(sw(), 8'h00);
				clr(c[0]);
			end
		end
		$display("threshold test done");
	endtask
	task timed(input bit c, input logic [1:0] u, input logic [9:0] cnt, input int len);
		cfg(c, 3'h0, u, cnt);
		sense(c, 8'h20);
		n = 0;
		d = 8'h00;
		while (d === 8'h00 && n < 2000) begin
			rd(8'h81);
			n += 2;
		end
		chk({7'h00, n >= cnt * len + 3 && n <= cnt * len + 6}, 8'h01);
		clr(c);
	endtask
	task testTiming();
		int len [4] = '{2, 5, 10, 20};
		for (int c = 0; c < 2; c++) begin
			for (int u = 0; u < 4; u++) timed(c[0], u[1:0], 10'h003, len[u]);
		end
		timed(0, 2'h0, 10'h101, 2);
		cfg(0, 3'h0, 2'h1, 10'h003);
		repeat (2) begin
			sense(0, 8'h20);
			repeat (12) cyc();
			sense(0, 8'h00);
			cyc();
		end
		rd(8'h81);
		chk(d, 8'h00);
		$display("timer test done");
	endtask
	// Short trip starts probing; another fault keeps it probing until it clears
	task testShort();
		wr(8'h87, 8'h00);
		attached = 1'b0;
		otherFault = 1'b1;
		probeWidth = 4'h2;
		shortPulse = 1'b1;
		cyc();
		shortPulse = 1'b0;
		waitSig(0, 1'b1);
		chk({7'h00, n >= 98 && n <= 103}, 8'h01);
		waitSig(0, 1'b0);
		chk({7'h00, n >= 9 && n <= 11}, 8'h01);
		waitSig(0, 1'b1);
		chk({7'h00, n >= 28 && n <= 32}, 8'h01);
		otherFault = 1'b0;
		waitSig(0, 1'b0);
		waitSig(0, 1'b1);
		chk({7'h00, n == 500}, 8'h01);
		probeWidth = 4'h1;
		$display("short recovery test done");
	endtask

	////////////////////////////////////////////////////////////////////////
	task testDone();
		$display("compared %0d, mismatches %0d", nCompared, numErrors);
		if (numErrors == 0 && nCompared > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Whole run needs about 2300 cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 20000) begin
			numErrors++;
			testDone();
		end
	end
	initial begin
		repeat (16) cyc();
		rst = 1'b0;
		cyc();
		testRegs();
		testRecover();
		testHostCtl();
		testOverride();
		testThresh();
		testTiming();
		testShort();
		testDone();
	end
endmodule
